// [common/iopd_pkg.sv]
// Purpose: constants for the port direction and pin sharing block
// Assumes: registers reached over a plain strobe port, byte data
// Notes: offsets are byte addresses in the special register space
// Function
// - direction bit 0 input, 1 output
// - single-bit set and clear writes supported
// - port 0 bit 4 input only
// - twelve pins over ports 0, 4, 5
// - reset option makes port 0 bit 4 reset
// - oscillator input on bit 3 for clock options other than IHRC
// - oscillator output on bit 2, not IHRC or RC
// - port 4 bit 0 analog channel zero
// - port 4 bits 1-4 analog by select
package iopd_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] IOPD_ADDR_P0DIR   = 8'hB8;
    localparam logic [7:0] IOPD_ADDR_P4DIR   = 8'hC4;
    localparam logic [7:0] IOPD_ADDR_P5DIR   = 8'hC5;
    localparam logic [7:0] IOPD_ADDR_BITOP   = 8'hC6;
    localparam logic [7:0] IOPD_ADDR_STATUS  = 8'hC7;
    localparam logic [7:0] IOPD_RST_VAL      = 8'h00;
    // implemented bit masks per port
    localparam logic [7:0] IOPD_P0_MASK      = 8'h0F;
    localparam logic [7:0] IOPD_P4_MASK      = 8'h1F;
    localparam logic [7:0] IOPD_P5_MASK      = 8'h18;
    // bit operation word: [7] set, [6] clear, [5:4] port, [2:0] bit
    localparam int IOPD_BOP_SET  = 7;
    localparam int IOPD_BOP_CLR  = 6;
    localparam int IOPD_BOP_PHI  = 5;
    localparam int IOPD_BOP_PLO  = 4;
    localparam int IOPD_BOP_BHI  = 2;
    localparam logic [1:0] IOPD_PSEL_P0 = 2'h0;
    localparam logic [1:0] IOPD_PSEL_P4 = 2'h1;
    localparam logic [1:0] IOPD_PSEL_P5 = 2'h2;
    // pin positions
    localparam int IOPD_P0_IRQ0  = 0;
    localparam int IOPD_P0_IRQ1  = 1;
    localparam int IOPD_P0_OSCILLATOR_OUT  = 2;
    localparam int IOPD_P0_XIN   = 3;
    localparam int IOPD_P0_RST   = 4;
    localparam int IOPD_P5_T1    = 3;
    localparam int IOPD_P5_T0    = 4;
    localparam int IOPD_P4_PINS  = 5;
    localparam int IOPD_PIN_COUNT = 12;
    localparam logic [2:0] IOPD_CHS_MAX = 3'h4;
    // high clock option encoding
    typedef enum logic [2:0] {
        IOPD_CLK_IHRC = 3'b000,
        IOPD_CLK_RC   = 3'b001,
        IOPD_CLK_32K  = 3'b010,
        IOPD_CLK_4M   = 3'b011,
        IOPD_CLK_12M  = 3'b100
    } iopd_clk_opt_t;
endpackage

// [core/iopd_top.sv]
// Purpose: port direction registers and shared pin steering
// Assumes: option straps are static, pins asynchronous to core_clk_i
// Notes: direction and output values are registered before the pads
`timescale 1ns/1ps
module iopd_top
    import iopd_pkg::*;
(
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic [7:0]              addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic [7:0]                   rdata_o,
    input  wire logic                    reset_pin_opt_i,
    input  wire iopd_pkg::iopd_clk_opt_t clk_opt_i,
    input  wire logic                    pin00_irq_enable_i,
    input  wire logic                    pin01_irq_enable_i,
    input  wire logic                    timer0_enable_i,
    input  wire logic                    timer1_enable_i,
    input  wire logic                    timer0_toggle_out_enable_i,
    input  wire logic                    timer1_toggle_out_enable_i,
    input  wire logic                    timer0_pulse_out_enable_i,
    input  wire logic                    timer1_pulse_out_enable_i,
    input  wire logic                    timer0_pulse_output_i,
    input  wire logic                    timer1_pulse_output_i,
    input  wire logic                    timer0_buzzer_output_i,
    input  wire logic                    timer1_buzzer_output_i,
    input  wire logic                    converter_enable_i,
    input  wire logic                    global_channel_enable_i,
    input  wire logic [2:0]              channel_select_i,
    input  wire logic [4:0]              p0_pin_i,
    input  wire logic [4:0]              p4_pin_i,
    input  wire logic [1:0]              p5_pin_i,
    input  wire logic [4:0]              p0_out_val_i,
    input  wire logic [4:0]              p4_out_val_i,
    input  wire logic [1:0]              p5_out_val_i,
    output logic [4:0]                   p0_pin_o,
    output logic [4:0]                   p0_pin_oe_o,
    output logic [4:0]                   p4_pin_o,
    output logic [4:0]                   p4_pin_oe_o,
    output logic [1:0]                   p5_pin_o,
    output logic [1:0]                   p5_pin_oe_o,
    output logic [4:0]                   p0_in_o,
    output logic [4:0]                   p4_in_o,
    output logic [1:0]                   p5_in_o,
    output logic                         ext_irq_zero_input_o,
    output logic                         ext_irq_one_input_o,
    output logic                         ext_reset_n_o,
    output logic                         oscillator_in_sel_o,
    output logic                         oscillator_out_sel_o,
    output logic [4:0]                   analog_channel_sel_o
);
    import iopd_pkg::*;

    // ****************************************
    // register bus
    // ****************************************
    logic [7:0]  p0_dir_q;
    logic [7:0]  p0_dir_d;
    logic [7:0]  p4_dir_q;
    logic [7:0]  p4_dir_d;
    logic [7:0]  p5_dir_q;
    logic [7:0]  p5_dir_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    wire         sel_p0   = (addr_i == IOPD_ADDR_P0DIR);
    wire         sel_p4   = (addr_i == IOPD_ADDR_P4DIR);
    wire         sel_p5   = (addr_i == IOPD_ADDR_P5DIR);
    wire         sel_bop  = (addr_i == IOPD_ADDR_BITOP);
    wire         sel_stat = (addr_i == IOPD_ADDR_STATUS);
    wire [1:0]   bop_port = wdata_i[IOPD_BOP_PHI:IOPD_BOP_PLO];
    wire [7:0]   bop_bit  = 8'h01 << wdata_i[IOPD_BOP_BHI:0];
    wire         bop_set  = wr_i && sel_bop && wdata_i[IOPD_BOP_SET];
    wire         bop_clr  = wr_i && sel_bop && wdata_i[IOPD_BOP_CLR] && !wdata_i[IOPD_BOP_SET];

    // one bit flips, neighbours untouched; set wins when both given
    function automatic logic [7:0] bit_op(input logic [7:0] cur, input logic [7:0] msk,
                                          input logic hit);
        logic [7:0] r;
        r = cur;
        if (hit && bop_set) begin
            r = cur | bop_bit;
        end else if (hit && bop_clr) begin
            r = cur & ~bop_bit;
        end
        return r & msk;
    endfunction

    // bit 4 of port 0 is masked so it never holds a direction
    assign p0_dir_d = (wr_i && sel_p0) ? (wdata_i & IOPD_P0_MASK)
                    : bit_op(p0_dir_q, IOPD_P0_MASK, bop_port == IOPD_PSEL_P0);
    assign p4_dir_d = (wr_i && sel_p4) ? (wdata_i & IOPD_P4_MASK)
                    : bit_op(p4_dir_q, IOPD_P4_MASK, bop_port == IOPD_PSEL_P4);
    assign p5_dir_d = (wr_i && sel_p5) ? (wdata_i & IOPD_P5_MASK)
                    : bit_op(p5_dir_q, IOPD_P5_MASK, bop_port == IOPD_PSEL_P5);

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NIN = IOPD_PIN_COUNT;
    wire  [NIN-1:0] pin_raw = {p5_pin_i, p4_pin_i, p0_pin_i};
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] s3_q;
    logic [NIN-1:0] in_q;
    logic [NIN-1:0] in_d;

    // change accepted only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            assign in_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : in_q[gi];
        end
    endgenerate

    // ****************************************
    // pin sharing
    // ****************************************
    wire clk_xin  = (clk_opt_i == IOPD_CLK_RC) || (clk_opt_i == IOPD_CLK_32K)
                 || (clk_opt_i == IOPD_CLK_4M) || (clk_opt_i == IOPD_CLK_12M);
    wire clk_oscillator_out = (clk_opt_i == IOPD_CLK_32K) || (clk_opt_i == IOPD_CLK_4M)
                 || (clk_opt_i == IOPD_CLK_12M);
    wire adc_on   = converter_enable_i && global_channel_enable_i;
    logic [4:0] ain_d;
    generate
        for (gi = 0; gi < IOPD_P4_PINS; gi++) begin : g_ain
            // a select above four points at no pin here
            assign ain_d[gi] = adc_on && (channel_select_i == 3'(gi))
                            && (channel_select_i <= IOPD_CHS_MAX);
        end
    endgenerate

    wire t0_pwm = timer0_enable_i && timer0_pulse_out_enable_i;
    wire t0_bz  = timer0_enable_i && timer0_toggle_out_enable_i && !timer0_pulse_out_enable_i;
    wire t1_pwm = timer1_enable_i && timer1_pulse_out_enable_i;
    wire t1_bz  = timer1_enable_i && timer1_toggle_out_enable_i && !timer1_pulse_out_enable_i;

    // port 0: bit 4 never drives; oscillator pins released to the pad
    logic [4:0] p0_oe_d;
    logic [4:0] p0_o_d;
    assign p0_oe_d = {1'b0,
                      p0_dir_q[IOPD_P0_XIN]  && !clk_xin,
                      p0_dir_q[IOPD_P0_OSCILLATOR_OUT] && !clk_oscillator_out,
                      p0_dir_q[1:0]};
    assign p0_o_d  = p0_out_val_i & {1'b0, 4'hF};
    // analog pins lose the digital driver
    logic [4:0] p4_oe_d;
    assign p4_oe_d = p4_dir_q[4:0] & ~ain_d;
    // port 5: peripheral takes the pin and drives it
    logic [1:0] p5_oe_d;
    logic [1:0] p5_o_d;
    assign p5_oe_d = {p5_dir_q[IOPD_P5_T0] || t0_pwm || t0_bz,
                      p5_dir_q[IOPD_P5_T1] || t1_pwm || t1_bz};
    assign p5_o_d  = {t0_pwm ? timer0_pulse_output_i : (t0_bz ? timer0_buzzer_output_i
                                                              : p5_out_val_i[1]),
                      t1_pwm ? timer1_pulse_output_i : (t1_bz ? timer1_buzzer_output_i
                                                              : p5_out_val_i[0])};
    wire [4:0] p0_in_w = in_q[4:0];
    wire [4:0] p4_in_w = in_q[9:5];
    wire [1:0] p5_in_w = in_q[11:10];

    // pin still readable as port input while it feeds the interrupt
    wire irq0_d = pin00_irq_enable_i ? p0_in_w[IOPD_P0_IRQ0] : 1'b1;
    wire irq1_d = pin01_irq_enable_i ? p0_in_w[IOPD_P0_IRQ1] : 1'b1;
    wire rstn_d = reset_pin_opt_i ? p0_in_w[IOPD_P0_RST] : 1'b1;
    // with the reset option the port bit reads as one
    wire [4:0] p0_rd = {reset_pin_opt_i | p0_in_w[IOPD_P0_RST], p0_in_w[3:0]};

    wire [7:0] status_w = {1'b0, clk_oscillator_out, clk_xin, adc_on, reset_pin_opt_i, t0_pwm,
                           t1_pwm, 1'b0};
    assign rdata_d = !rd_i ? IOPD_RST_VAL
                   : sel_p0   ? p0_dir_q
                   : sel_p4   ? p4_dir_q
                   : sel_p5   ? p5_dir_q
                   : sel_stat ? status_w
                   : IOPD_RST_VAL;

    // ****************************************
    // registers
    // ****************************************
    logic [4:0] p0_oe_q;
    logic [4:0] p0_o_q;
    logic [4:0] p4_oe_q;
    logic [4:0] p4_o_q;
    logic [1:0] p5_oe_q;
    logic [1:0] p5_o_q;
    logic [4:0] p0_in_q;
    logic [4:0] p4_in_q;
    logic [1:0] p5_in_q;
    logic       irq0_q;
    logic       irq1_q;
    logic       rstn_q;
    logic       xin_q;
    logic       oscillator_out_q;
    logic [4:0] ain_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            p0_dir_q <= IOPD_RST_VAL;
            p4_dir_q <= IOPD_RST_VAL;
            p5_dir_q <= IOPD_RST_VAL;
            rdata_q  <= IOPD_RST_VAL;
        end else begin
            p0_dir_q <= p0_dir_d;
            p4_dir_q <= p4_dir_d;
            p5_dir_q <= p5_dir_d;
            rdata_q  <= rdata_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            in_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= in_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            p0_oe_q <= '0;
            p0_o_q  <= '0;
            p4_oe_q <= '0;
            p4_o_q  <= '0;
            p5_oe_q <= '0;
            p5_o_q  <= '0;
        end else begin
            p0_oe_q <= p0_oe_d;
            p0_o_q  <= p0_o_d;
            p4_oe_q <= p4_oe_d;
            p4_o_q  <= p4_out_val_i;
            p5_oe_q <= p5_oe_d;
            p5_o_q  <= p5_o_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            p0_in_q <= '0;
            p4_in_q <= '0;
            p5_in_q <= '0;
            irq0_q  <= 1'b1;
            irq1_q  <= 1'b1;
            rstn_q  <= 1'b1;
            xin_q   <= 1'b0;
            oscillator_out_q  <= 1'b0;
            ain_q   <= '0;
        end else begin
            p0_in_q <= p0_rd;
            p4_in_q <= p4_in_w;
            p5_in_q <= p5_in_w;
            irq0_q  <= irq0_d;
            irq1_q  <= irq1_d;
            rstn_q  <= rstn_d;
            xin_q   <= clk_xin;
            oscillator_out_q  <= clk_oscillator_out;
            ain_q   <= ain_d;
        end
    end

    assign rdata_o              = rdata_q;
    assign p0_pin_o             = p0_o_q;
    assign p0_pin_oe_o          = p0_oe_q;
    assign p4_pin_o             = p4_o_q;
    assign p4_pin_oe_o          = p4_oe_q;
    assign p5_pin_o             = p5_o_q;
    assign p5_pin_oe_o          = p5_oe_q;
    assign p0_in_o              = p0_in_q;
    assign p4_in_o              = p4_in_q;
    assign p5_in_o              = p5_in_q;
    assign ext_irq_zero_input_o = irq0_q;
    assign ext_irq_one_input_o  = irq1_q;
    assign ext_reset_n_o        = rstn_q;
    assign oscillator_in_sel_o  = xin_q;
    assign oscillator_out_sel_o = oscillator_out_q;
    assign analog_channel_sel_o = ain_q;

    // ****************************************
    // checks
    // ****************************************
    sequence s_bitset;
        wr_i && sel_bop && wdata_i[IOPD_BOP_SET] && bop_port == IOPD_PSEL_P4
            && wdata_i[IOPD_BOP_BHI:0] == 3'h1;
    endsequence

    AST_DIR_IN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 (p4_dir_q[0] == 1'b0) |=> (p4_pin_oe_o[0] == 1'b0))
        else $error("input pin drives");
    AST_BIT_SET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_bitset |=> (p4_dir_q[1] && p4_dir_q[4:2] == $past(p4_dir_q[4:2])))
        else $error("bit set disturbed neighbours");
    AST_BIT_CLR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (bop_clr && bop_port == IOPD_PSEL_P0 && wdata_i[IOPD_BOP_BHI:0] == 3'h0)
        |=> (!p0_dir_q[0] && p0_dir_q[3:1] == $past(p0_dir_q[3:1])))
        else $error("bit clear failed");
    AST_P04_IN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !p0_pin_oe_o[IOPD_P0_RST] && !p0_dir_q[IOPD_P0_RST])
        else $error("input-only pin driven");
    AST_RST_PIN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (!reset_pin_opt_i && $stable(reset_pin_opt_i)) |=> ext_reset_n_o)
        else $error("reset without option");
    AST_XIN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_opt_i == IOPD_CLK_RC) |=> (oscillator_in_sel_o && !oscillator_out_sel_o
            && !p0_pin_oe_o[IOPD_P0_XIN]))
        else $error("rc option steering wrong");
    AST_OSCILLATOR_OUT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_opt_i == IOPD_CLK_4M) |=> (oscillator_out_sel_o && !p0_pin_oe_o[IOPD_P0_OSCILLATOR_OUT]))
        else $error("oscillator_out not released");
    AST_AIN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (adc_on && channel_select_i == 3'h2) |=> (analog_channel_sel_o == 5'h04
            && !p4_pin_oe_o[2]))
        else $error("analog channel wrong");
    AST_PWM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        t0_pwm |=> (p5_pin_oe_o[1] && p5_pin_o[1] == $past(timer0_pulse_output_i)))
        else $error("pulse output missing");
    AST_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pin00_irq_enable_i |=> (ext_irq_zero_input_o == $past(p0_in_w[IOPD_P0_IRQ0])
            && p0_in_o[IOPD_P0_IRQ0] == ext_irq_zero_input_o))
        else $error("irq feed wrong");
    AST_ANALOG_CHANNEL_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (converter_enable_i && global_channel_enable_i && channel_select_i == 3'h0)
        |=> (analog_channel_sel_o[0] && !p4_pin_oe_o[0]))
        else $error("analog channel zero wrong");
    AST_AIN_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !global_channel_enable_i |=> (analog_channel_sel_o == 5'h00))
        else $error("analog channel without enable");
    AST_BZ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        t1_bz |=> (p5_pin_oe_o[0] && p5_pin_o[0] == $past(timer1_buzzer_output_i)))
        else $error("buzzer output missing");
endmodule

// [verif/iopd_board.sv]
// Purpose: board circuitry seen by the port pins
// Assumes: every pin has a pull-up on the board
// Notes: device drive wins, else board drive, else pull-up level
`timescale 1ns/1ps
module iopd_board (
    input  wire logic [4:0] p0_pin_o,
    input  wire logic [4:0] p0_pin_oe_o,
    input  wire logic [4:0] p4_pin_o,
    input  wire logic [4:0] p4_pin_oe_o,
    input  wire logic [1:0] p5_pin_o,
    input  wire logic [1:0] p5_pin_oe_o,
    input  wire logic [4:0] b0_en_i,
    input  wire logic [4:0] b0_val_i,
    input  wire logic [4:0] b4_en_i,
    input  wire logic [4:0] b4_val_i,
    input  wire logic [1:0] b5_en_i,
    input  wire logic [1:0] b5_val_i,
    output logic [4:0]      p0_pin_i,
    output logic [4:0]      p4_pin_i,
    output logic [1:0]      p5_pin_i
);
    // ****************************************
    // wire resolution
    // ****************************************
    // released pins not driven by the board float to the pull-up, never to a stale value
    assign p0_pin_i = (p0_pin_oe_o & p0_pin_o) | (~p0_pin_oe_o & ~(b0_en_i & ~b0_val_i));
    assign p4_pin_i = (p4_pin_oe_o & p4_pin_o) | (~p4_pin_oe_o & ~(b4_en_i & ~b4_val_i));
    assign p5_pin_i = (p5_pin_oe_o & p5_pin_o) | (~p5_pin_oe_o & ~(b5_en_i & ~b5_val_i));
endmodule

// [verif/testbench.sv]
// Purpose: self-checking bench for port direction and pin sharing
// Assumes: straps change only while the bench waits for settling
// Notes: settle covers pin sync, filter and output register
`timescale 1ns/1ps
module testbench;
    import iopd_pkg::*;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic reset_pin_opt_i = 1'b0, pin00_irq_enable_i = 1'b0, pin01_irq_enable_i = 1'b0;
    iopd_clk_opt_t clk_opt_i = IOPD_CLK_IHRC;
    logic [1:0] t_en = 2'h0, t_te = 2'h0, t_pe = 2'h0, t_po = 2'h0, t_bz = 2'h0;
    logic converter_enable_i = 1'b0, global_channel_enable_i = 1'b0;
    logic [2:0] channel_select_i = 3'h0;
    logic [4:0] p0_out_val_i = 5'h0A, p4_out_val_i = 5'h15, b0_en = 5'h00, b0_val = 5'h00;
    logic [1:0] p5_out_val_i = 2'h0;
    logic [4:0] p0_pin_i, p4_pin_i, p0_pin_o, p0_pin_oe_o, p4_pin_o, p4_pin_oe_o;
    logic [4:0] p0_in_o, p4_in_o, analog_channel_sel_o;
    logic [1:0] p5_pin_i, p5_pin_o, p5_pin_oe_o, p5_in_o;
    logic ext_irq_zero_input_o, ext_irq_one_input_o, ext_reset_n_o;
    logic oscillator_in_sel_o, oscillator_out_sel_o;
    int n_mismatch = 0;
    int checked = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    iopd_top dut (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .reset_pin_opt_i, .clk_opt_i, .pin00_irq_enable_i, .pin01_irq_enable_i,
        .timer0_enable_i(t_en[0]), .timer1_enable_i(t_en[1]),
        .timer0_toggle_out_enable_i(t_te[0]), .timer1_toggle_out_enable_i(t_te[1]),
        .timer0_pulse_out_enable_i(t_pe[0]), .timer1_pulse_out_enable_i(t_pe[1]),
        .timer0_pulse_output_i(t_po[0]), .timer1_pulse_output_i(t_po[1]),
        .timer0_buzzer_output_i(t_bz[0]), .timer1_buzzer_output_i(t_bz[1]),
        .converter_enable_i, .global_channel_enable_i, .channel_select_i,
        .p0_pin_i, .p4_pin_i, .p5_pin_i, .p0_out_val_i, .p4_out_val_i, .p5_out_val_i,
        .p0_pin_o, .p0_pin_oe_o, .p4_pin_o, .p4_pin_oe_o, .p5_pin_o, .p5_pin_oe_o,
        .p0_in_o, .p4_in_o, .p5_in_o, .ext_irq_zero_input_o, .ext_irq_one_input_o,
        .ext_reset_n_o, .oscillator_in_sel_o, .oscillator_out_sel_o, .analog_channel_sel_o);

    iopd_board board (.p0_pin_o, .p0_pin_oe_o, .p4_pin_o, .p4_pin_oe_o, .p5_pin_o,
        .p5_pin_oe_o, .b0_en_i(b0_en), .b0_val_i(b0_val), .b4_en_i(5'h00),
        .b4_val_i(5'h00), .b5_en_i(2'h0), .b5_val_i(2'h0), .p0_pin_i, .p4_pin_i, .p5_pin_i);

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic settle;
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [7:0] d;
        logic [7:0] ad [3] = '{IOPD_ADDR_P0DIR, IOPD_ADDR_P4DIR, IOPD_ADDR_P5DIR};
        logic [7:0] mk [3] = '{8'h0F, 8'h1F, 8'h18};
        for (int i = 0; i < 3; i++) begin
            bus_rd(ad[i], d);
            chk("dir reset", IOPD_RST_VAL, d);
            bus_wr(ad[i], 8'hFF);
            bus_rd(ad[i], d);
            chk("dir mask", mk[i], d);
        end
        bus_rd(8'h50, d);
        chk("unmapped read", 8'h00, d);
        settle();
        chk("p0 oe", 8'h0F, {3'h0, p0_pin_oe_o});
        chk("p4 oe", 8'h1F, {3'h0, p4_pin_oe_o});
        chk("p4 data", 8'h15, {3'h0, p4_pin_o});
        chk("p5 oe", 8'h03, {6'h0, p5_pin_oe_o});
        chk("p0 data", 8'h0A, {3'h0, p0_pin_o});
        chk("p4 in", 8'h15, {3'h0, p4_in_o});
        chk("p5 in", 8'h00, {6'h0, p5_in_o});
        $display("test regs done");
    endtask

    task automatic t_bitop;
        logic [7:0] d;
        bus_wr(IOPD_ADDR_BITOP, 8'h52);
        bus_wr(IOPD_ADDR_BITOP, 8'h51);
        bus_rd(IOPD_ADDR_P4DIR, d);
        chk("bit clear p4.2 p4.1", 8'h19, d);
        settle();
        chk("p4 oe after clear", 8'h19, {3'h0, p4_pin_oe_o});
        bus_wr(IOPD_ADDR_BITOP, 8'h92);
        bus_wr(IOPD_ADDR_BITOP, 8'h91);
        bus_wr(IOPD_ADDR_BITOP, 8'h40);
        bus_wr(IOPD_ADDR_BITOP, 8'h41);
        bus_wr(IOPD_ADDR_BITOP, 8'hC0);
        bus_rd(IOPD_ADDR_P4DIR, d);
        chk("bit set p4.2 p4.1", 8'h1F, d);
        bus_rd(IOPD_ADDR_P0DIR, d);
        chk("bit ops p0", 8'h0D, d);
        $display("test bitop done");
    endtask

    task automatic t_osc;
        logic xi;
        logic xo;
        logic [7:0] d;
        for (int k = 0; k < 5; k++) begin
            clk_opt_i <= iopd_clk_opt_t'(k);
            xi = (k >= 1);
            xo = (k >= 2);
            settle();
            chk("osc in sel", {7'h0, xi}, {7'h0, oscillator_in_sel_o});
            chk("osc out sel", {7'h0, xo}, {7'h0, oscillator_out_sel_o});
            chk("p0 oe osc", {6'h0, ~xi, ~xo}, {6'h0, p0_pin_oe_o[3:2]});
            bus_rd(IOPD_ADDR_STATUS, d);
            chk("status osc", {1'b0, xo, xi, 5'h00}, d);
        end
        clk_opt_i <= IOPD_CLK_IHRC;
        $display("test osc done");
    endtask

    task automatic t_adc;
        logic [4:0] e;
        logic [7:0] d;
        converter_enable_i <= 1'b1;
        global_channel_enable_i <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            channel_select_i <= 3'(k);
            e = (k < 5) ? 5'(1 << k) : 5'h00;
            settle();
            chk("analog sel", {3'h0, e}, {3'h0, analog_channel_sel_o});
            chk("p4 oe analog", {3'h0, 5'h1F & ~e}, {3'h0, p4_pin_oe_o});
        end
        bus_rd(IOPD_ADDR_STATUS, d);
        chk("status adc", 8'h10, d);
        channel_select_i <= 3'h0;
        global_channel_enable_i <= 1'b0;
        settle();
        chk("analog off", 8'h00, {3'h0, analog_channel_sel_o});
        converter_enable_i <= 1'b0;
        $display("test adc done");
    endtask

    // pin bit 1 is P5.4 for timer 0, bit 0 is P5.3 for timer 1
    task automatic t_timer;
        logic [7:0] got;
        bus_wr(IOPD_ADDR_P5DIR, 8'h00);
        for (int i = 0; i < 2; i++) begin
            t_en[i] <= 1'b1;
            t_pe[i] <= 1'b1;
            t_po[i] <= 1'b1;
            settle();
            chk("pwm drive", 8'h03, {6'h0, p5_pin_oe_o[1-i], p5_pin_o[1-i]});
            t_pe[i] <= 1'b0;
            t_te[i] <= 1'b1;
            for (int b = 0; b < 2; b++) begin
                t_bz[i] <= 1'(b);
                settle();
                got = {6'h0, p5_pin_oe_o[1-i], p5_pin_o[1-i]};
                chk("buzzer", {7'h01, 1'(b)}, got);
            end
            t_en[i] <= 1'b0;
        end
        $display("test timer done");
    endtask

    task automatic t_pins;
        bus_wr(IOPD_ADDR_P0DIR, 8'h00);
        pin00_irq_enable_i <= 1'b1;
        pin01_irq_enable_i <= 1'b1;
        b0_en <= 5'h13;
        settle();
        chk("irq lines low", 8'h00, {6'h0, ext_irq_one_input_o, ext_irq_zero_input_o});
        chk("p0 in", 8'h0C, {3'h0, p0_in_o});
        pin00_irq_enable_i <= 1'b0;
        pin01_irq_enable_i <= 1'b0;
        settle();
        chk("irq lines idle", 8'h03, {6'h0, ext_irq_one_input_o, ext_irq_zero_input_o});
        chk("p0.4 as input", 8'h00, {7'h0, p0_in_o[4]});
        reset_pin_opt_i <= 1'b1;
        settle();
        chk("reset pin", 8'h01, {7'h0, p0_in_o[4]});
        chk("ext reset", 8'h00, {7'h0, ext_reset_n_o});
        $display("test pins done");
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_bitop();
        t_osc();
        t_adc();
        t_timer();
        t_pins();
        wrap_up();
    end

    initial begin
        #100000;
        n_mismatch++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
